// >>> design/sccr_slave_cfg.sv
`timescale 1ns/1ns
module sccr_slave_cfg
   import sccr_pkg::*;
#(
   parameter logic [3:0] PORT_ASYNC = 4'hf,
   parameter logic REG_ASYNC = 1'b0,
   parameter logic DDR_ON = 1'b0,
   parameter logic [1:0] MEM_CLK_CODE = 2'b10,
   parameter logic [2:0] UNFOLD_CODE = 3'b000,
   parameter logic [2:0] ENGINE_CODE = 3'b000,
   parameter logic [1:0] FFM_CODE = 2'b00,
   parameter logic [1:0] BUS_W_CODE = 2'b00,
   parameter logic [1:0] FLOW_SRAM_CODE = 2'b00,
   parameter logic EXT_BUS_ON = 1'b0,
   parameter logic [2:0] CMDQ_DEPTH = 3'h4,
   parameter logic [2:0] PORT_COUNT = 3'h4,
   parameter logic [3:0] CHANNEL_COUNT = 4'h8,
   parameter logic [31:0] CAP_LOW = 32'h0000_ffff,
   parameter logic [31:0] CAP_MID = 32'h0000_0000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Data port side
   input wire logic [11:0] port_hburst,
   input wire logic [3:0] port_reset_done,
   output logic [35:0] port_fetch_len,
   output logic [3:0] port_retry_en,
   output logic [67:0] port_window_bytes,
   output logic [3:0] port_reset,
   // Core side
   output logic whole_block_reset
);

   // ****************************************************
   // Helpers
   // ****************************************************

   // Burst words for a length taken from the burst code; wraps are
   // fetched in plain order, since a region is a queue, not a memory
   function automatic logic [8:0] burst_words(input logic [2:0] code);
      case (code)
         BURST_WRAP4, BURST_INCR4: burst_words = 9'h004;
         BURST_WRAP8, BURST_INCR8: burst_words = 9'h008;
         BURST_WRAP16, BURST_INCR16: burst_words = 9'h010;
         default: burst_words = 9'h001;
      endcase
   endfunction

   // One-hot window code to bytes; a code with no bit set gives zero
   function automatic logic [16:0] window_bytes(input logic [7:0] code);
      logic [16:0] bytes;
      bytes = 17'h00000;
      for (int i = 0; i < 8; i++) begin
         if (code[i]) begin
            bytes = WINDOW_MIN_BYTES << i;
         end
      end
      return bytes;
   endfunction

   // ****************************************************
   // Build constants
   // ****************************************************

   // Feature word assembled from build parameters only
   logic [31:0] feature_word;
   assign feature_word = {DDR_ON, PORT_ASYNC, REG_ASYNC, MEM_CLK_CODE,
                          UNFOLD_CODE, ENGINE_CODE, FFM_CODE,
                          BUS_W_CODE, FLOW_SRAM_CODE, EXT_BUS_ON,
                          CMDQ_DEPTH, 1'b0, PORT_COUNT, CHANNEL_COUNT};

   // ****************************************************
   // Bus decode
   // ****************************************************

   logic bus_req; // New request this cycle
   logic wr_req; // Write being taken
   logic [31:0] wmask; // Byte lanes as a bit mask
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_req = bus_req && wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // ****************************************************
   // Window and prefetch register
   // ****************************************************

   sccr_window_t window; // Stored fields
   logic [31:0] window_word; // Read view
   logic [31:0] next_window_word; // Word after a masked write
   assign window_word = {7'h00, window.pf_len, window.force_len, window.retry_en, window.range};
   assign next_window_word = (window_word & ~wmask) | (wb_dat_i & wmask);

   // Software writes; the global reset leaves this register alone
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         window.pf_len <= PF_LEN_RST;
         window.force_len <= FORCE_RST;
         window.retry_en <= RETRY_RST;
         window.range <= RANGE_RST;
      end else if (wr_req && wb_adr_i == WINDOW_OFS) begin
         window.pf_len <= next_window_word[PF_LEN_LSB +: 9];
         window.force_len <= next_window_word[FORCE_LSB +: 4];
         window.retry_en <= next_window_word[RETRY_LSB +: 4];
         window.range <= next_window_word[RANGE_LSB +: 8];
      end
   end

   // ****************************************************
   // Per-port settings
   // ****************************************************

   // Length source chosen per port; same-clock ports fetch one word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port_fetch_len <= 36'h0;
         port_retry_en <= RETRY_RST;
         port_window_bytes <= 68'h0;
      end else begin
         for (int p = 0; p < 4; p++) begin
            if (!PORT_ASYNC[p]) begin
               port_fetch_len[p*9 +: 9] <= 9'h001;
            end else if (window.force_len[p]) begin
               port_fetch_len[p*9 +: 9] <= window.pf_len;
            end else begin
               port_fetch_len[p*9 +: 9] <= burst_words(port_hburst[p*3 +: 3]);
            end
            port_window_bytes[p*17 +: 17] <= window_bytes(window.range);
         end
         port_retry_en <= window.retry_en;
      end
   end

   // ****************************************************
   // Global reset sequencer
   // ****************************************************

   sccr_glb_state_t glb_state; // Sequencer state
   logic [3:0] glb_count; // Pulse length counter
   logic glb_kick; // Software asked for reset
   assign glb_kick = wr_req && wb_adr_i == GLB_RST_OFS && wb_sel_i[0] && wb_dat_i[GLB_RST_BIT];

   // Pulse for a fixed time, then one idle cycle so a second write
   // lands cleanly; writes during the pulse are absorbed
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         glb_state <= GR_IDLE;
         glb_count <= 4'h0;
         whole_block_reset <= 1'b0;
      end else begin
         case (glb_state)
            GR_IDLE: begin
               if (glb_kick) begin
                  glb_state <= GR_PULSE;
                  glb_count <= 4'(GLB_PULSE_CYC - 1);
                  whole_block_reset <= 1'b1;
               end
            end
            GR_PULSE: begin
               if (glb_count == 4'h0) begin
                  glb_state <= GR_HOLD;
                  whole_block_reset <= 1'b0;
               end else begin
                  glb_count <= glb_count - 4'h1;
               end
            end
            GR_HOLD: begin
               glb_state <= GR_IDLE;
            end
            default: begin
               glb_state <= GR_IDLE;
               whole_block_reset <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************
   // Per-port soft reset
   // ****************************************************

   // Done level comes from the port clock: three stages, a change
   // counts only once the second and third agree
   logic [3:0] done_s1;
   logic [3:0] done_s2;
   logic [3:0] done_s3;
   logic [3:0] done_level; // Filtered done
   logic [3:0] done_rise; // Filtered done went high
   logic [3:0] rst_set; // Software start request

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done_s1 <= 4'h0;
         done_s2 <= 4'h0;
         done_s3 <= 4'h0;
         done_level <= 4'h0;
      end else begin
         done_s1 <= port_reset_done;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
         for (int p = 0; p < 4; p++) begin
            if (done_s2[p] == done_s3[p]) begin
               done_level[p] <= done_s3[p];
            end
         end
      end
   end

   assign done_rise = {4{1'b1}} & ~done_level & done_s2 & done_s3;
   // Same-clock ports ignore the write; they have no separate reset
   assign rst_set = (wr_req && wb_adr_i == PORT_RST_OFS && wb_sel_i[0]) ?
                    (wb_dat_i[3:0] & PORT_ASYNC) : 4'h0;

   // Held until the port reports done; a new write wins over done
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port_reset <= 4'h0;
      end else begin
         port_reset <= rst_set | (port_reset & ~done_rise);
      end
   end

   // ****************************************************
   // Read mux
   // ****************************************************

   // Build words ignore writes; unmapped reads return zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= 32'h0;
      end else if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            FEATURE_OFS: wb_dat_o <= feature_word;
            WINDOW_OFS: wb_dat_o <= window_word;
            PORT_RST_OFS: wb_dat_o <= {28'h0, port_reset};
            CAP_LOW_OFS: wb_dat_o <= CAP_LOW;
            CAP_MID_OFS: wb_dat_o <= CAP_MID;
            default: wb_dat_o <= 32'h0;
         endcase
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence glb_write_s;
      glb_kick && glb_state == GR_IDLE;
   endsequence

   sequence glb_pulse_s;
      whole_block_reset [*4] ##1 !whole_block_reset;
   endsequence

   glb_pulse_len_a: assert property (glb_write_s |=> glb_pulse_s)
      else $error("global reset pulse has wrong length");

   feature_const_a: assert property (bus_req && !wb_we_i && wb_adr_i == FEATURE_OFS |=>
      wb_dat_o[30:27] == PORT_ASYNC && wb_dat_o[26] == REG_ASYNC && wb_dat_o[7] == 1'b0)
      else $error("feature word flags wrong");

   feature_codes_a: assert property (bus_req && !wb_we_i && wb_adr_i == FEATURE_OFS |=>
      wb_dat_o[25:24] == MEM_CLK_CODE && wb_dat_o[11] == EXT_BUS_ON && wb_dat_o[3:0] == CHANNEL_COUNT)
      else $error("feature word codes wrong");

   cap_read_a: assert property (bus_req && !wb_we_i && wb_adr_i == CAP_MID_OFS |=> wb_dat_o == CAP_MID)
      else $error("capability word wrong");

   retry_reset_a: assert property ($rose(reset_n) |-> port_retry_en == 4'hf)
      else $error("retry enables not set after reset");

   prefetch_write_a: assert property (wr_req && wb_adr_i == WINDOW_OFS && wb_sel_i[2] |=>
      window.pf_len[7:0] == $past(wb_dat_i[23:16]))
      else $error("prefetch length not stored");

   sync_port_len_a: assert property (!PORT_ASYNC[1] |=> port_fetch_len[17:9] == 9'h001)
      else $error("same-clock port got a programmed length");

   forced_len_a: assert property (PORT_ASYNC[0] && window.force_len[0] |=>
      port_fetch_len[8:0] == $past(window.pf_len))
      else $error("forced length not applied");

   burst_len_a: assert property (PORT_ASYNC[2] && !window.force_len[2] && port_hburst[8:6] == BURST_INCR4 |=>
      port_fetch_len[26:18] == 9'h004)
      else $error("burst length wrong");

   port_rst_self_a: assert property (port_reset[0] && done_rise[0] && !rst_set[0] |=> !port_reset[0])
      else $error("port reset did not clear");

   port_rst_sync_a: assert property (wr_req && wb_adr_i == PORT_RST_OFS && wb_dat_i[1] && !PORT_ASYNC[1] |=>
      !port_reset[1])
      else $error("same-clock port reset accepted");

   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

endmodule

// >>> dv/sccr_port_model.sv
`timescale 1ns/1ns
module sccr_port_model
   import sccr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Settings from the bench
   input wire logic [2:0] burst,
   input wire logic [3:0] slow,
   // Port side of the block
   input wire logic [3:0] port_reset,
   output logic [11:0] port_hburst,
   output logic [3:0] port_reset_done
);
   // ****************************************************
   // Burst kind seen on every port
   // ****************************************************
   // One master per port, one burst kind at a time
   assign port_hburst = {4{burst}};

   // ****************************************************
   // Per-port reset handshake
   // ****************************************************
   for (genvar p = 0; p < 4; p++) begin : g_port
      logic [4:0] cnt; // Step of one reset handshake
      logic [4:0] lim; // Slow ports take longer to finish
      assign lim = slow[p] ? 5'h0c : 5'h02;
      // Count from request through done hold
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            cnt <= 5'h00;
         end else if (port_reset[p] || cnt != 5'h00) begin
            cnt <= (cnt == lim + 5'h08) ? 5'h00 : cnt + 5'h01;
         end
      end
      // Done stands six cycles, longer than the synchroniser needs
      assign port_reset_done[p] = (cnt > lim) && (cnt <= lim + 5'h06);
   end
endmodule

// >>> dv/sccr_slave_cfg_tb.sv
`timescale 1ns/1ns
module sccr_slave_cfg_tb
   import sccr_pkg::*;
;
   // ****************************************************
   // Build settings, chosen away from the defaults
   // ****************************************************
   localparam logic [3:0] PA = 4'h5; // Ports 0 and 2 async
   localparam logic [31:0] CLO = 32'h8000_0005; // Arbitrary bitmap
   localparam logic [31:0] CMI = 32'h0000_00a3; // Arbitrary bitmap
   localparam logic [31:0] FEAT = {1'b1, PA, 1'b1, 2'b01, 3'b100, 3'b111, 2'b10, 2'b10, 2'b01, 1'b1,
      3'h2, 1'b0, 3'h3, 4'h4};

   logic clk = 1'b0; // Bus clock
   logic reset_n = 1'b0; // Active low reset
   logic cyc = 1'b0; // Bus request
   logic we = 1'b0; // Write strobe
   logic [11:0] adr = 12'h000; // Byte address
   logic [31:0] wdat = 32'h0; // Write data
   logic [3:0] sel = 4'hf; // Byte lanes on the bus
   logic [3:0] lanes = 4'hf; // Lanes for the next request
   logic [3:0] slow = 4'h4; // Port 2 answers slowly
   int glb_base = 0; // Pulse count before a write
   logic [31:0] rdat; // Read data
   logic ack; // Bus answer
   logic [2:0] burst = BURST_INCR; // Burst kind on ports
   logic [11:0] hburst; // Burst codes to block
   logic [3:0] done; // Port reset done levels
   logic [35:0] fetch; // Prefetch lengths
   logic [3:0] retry; // Retry enables
   logic [67:0] wbytes; // Window sizes
   logic [3:0] preset; // Port resets
   logic glb; // Whole-block reset
   logic [31:0] q; // Last read value
   int glb_hi = 0; // Cycles of global reset seen
   int num_errors = 0;
   int n_compared = 0;

   sccr_slave_cfg #(.PORT_ASYNC(PA), .REG_ASYNC(FEAT[26]), .DDR_ON(FEAT[31]), .MEM_CLK_CODE(FEAT[25:24]),
      .UNFOLD_CODE(FEAT[23:21]), .ENGINE_CODE(FEAT[20:18]), .FFM_CODE(FEAT[17:16]), .BUS_W_CODE(FEAT[15:14]),
      .FLOW_SRAM_CODE(FEAT[13:12]), .EXT_BUS_ON(FEAT[11]), .CMDQ_DEPTH(FEAT[10:8]), .PORT_COUNT(FEAT[6:4]),
      .CHANNEL_COUNT(FEAT[3:0]), .CAP_LOW(CLO), .CAP_MID(CMI)) i_sccr_slave_cfg (
      .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .port_hburst(hburst), .port_reset_done(done), .port_fetch_len(fetch),
      .port_retry_en(retry), .port_window_bytes(wbytes), .port_reset(preset),
      .whole_block_reset(glb));

   // Far side: port 2 answers slowly
   sccr_port_model i_sccr_port_model (.clk(clk), .reset_n(reset_n), .burst(burst),
      .slow(slow), .port_reset(preset), .port_hburst(hburst), .port_reset_done(done));

   // ****************************************************
   // Clock and monitors
   // ****************************************************
   initial begin
      forever #25 clk = ~clk;
   end
   // Length of the global reset pulse
   always @(posedge clk) begin
      if (glb === 1'b1) glb_hi <= glb_hi + 1;
   end

   // ****************************************************
   // Helpers
   // ****************************************************
   task end_sim;
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Compare seen against expected
   task chk(input logic [67:0] got, input logic [67:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One classic cycle; holds until ack, then one idle cycle
   task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      sel <= lanes;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      if (n >= 20) begin
         num_errors++;
         end_sim();
      end
      @(posedge clk);
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      // Reset contents and outputs
      wb(1'b0, WINDOW_OFS, 32'h0);
      chk(q, 32'h0001_0f01);
      chk(retry, 4'hf);
      chk(wbytes, {4{17'h00200}});
      // Build words, then writes to them must not stick
      wb(1'b1, FEATURE_OFS, 32'h0);
      wb(1'b0, FEATURE_OFS, 32'h0);
      chk(q, FEAT);
      chk(q[31:12], FEAT[31:12]);
      chk(q[11:0], FEAT[11:0]);
      chk(q[23:16], FEAT[23:16]);
      chk(q[15:12], FEAT[15:12]);
      chk(q[10:0], FEAT[10:0]);
      wb(1'b1, CAP_LOW_OFS, 32'h0);
      wb(1'b0, CAP_LOW_OFS, 32'h0);
      chk(q, CLO);
      wb(1'b1, CAP_MID_OFS, 32'hffff_ffff);
      wb(1'b0, CAP_MID_OFS, 32'h0);
      chk(q, CMI);
      // Unmapped space reads zero and ignores writes
      wb(1'b1, 12'h600, 32'hffff_ffff);
      wb(1'b0, 12'h600, 32'h0);
      chk(q, 32'h0);
      // Every one-hot window size
      for (int k = 0; k < 8; k++) begin
         // 64 words fit every window, a 512-byte sector and 32-bit data; ports 1 and 3 keep retry
         wb(1'b1, WINDOW_OFS, {7'h00, 9'h040, 4'h1, 4'ha, 8'h01 << k});
         repeat (2) @(posedge clk);
         chk(wbytes, {4{17'h00200 << k}});
      end
      wb(1'b0, WINDOW_OFS, 32'h0);
      chk(q, 32'h0040_1a80);
      chk(retry, 4'ha);
      // Burst-decided length on port 2, fixed on the others
      for (int k = 0; k < 4; k++) begin
         burst <= (k == 0) ? BURST_INCR : (k == 1) ? BURST_INCR4 : (k == 2) ? BURST_WRAP8 : BURST_INCR16;
         repeat (3) @(posedge clk);
         chk(fetch[26:18], (k == 0) ? 9'h001 : 9'h004 << (k - 1));
         chk(fetch[8:0], 9'h040);
         chk({fetch[35:27], fetch[17:9]}, {9'h001, 9'h001});
      end
      // Global reset: four cycles, registers kept
      glb_base = glb_hi;
      wb(1'b1, GLB_RST_OFS, 32'h1);
      // Software waits out the reset before going on
      repeat (8) @(posedge clk);
      chk(glb_hi - glb_base, GLB_PULSE_CYC);
      wb(1'b0, WINDOW_OFS, 32'h0);
      chk(q, 32'h0040_1a80);
      // Byte lanes: only lane 2 lands; a reset write without lane 0 does nothing
      lanes = 4'h4;
      wb(1'b1, WINDOW_OFS, 32'hff20_ffff);
      lanes = 4'he;
      glb_base = glb_hi;
      wb(1'b1, GLB_RST_OFS, 32'h1);
      repeat (8) @(posedge clk);
      chk(glb_hi - glb_base, 0);
      lanes = 4'hf;
      wb(1'b0, WINDOW_OFS, 32'h0);
      chk(q, 32'h0020_1a80);
      wb(1'b0, GLB_RST_OFS, 32'h0);
      chk(q, 32'h0);
      // Port resets: same-clock port 1 ignored, others clear
      wb(1'b1, PORT_RST_OFS, 32'h7);
      wb(1'b0, PORT_RST_OFS, 32'h0);
      chk(q, 32'h5);
      chk(preset, 4'h5);
      for (int n = 0; n < 40 && q !== 32'h0; n++) begin
         wb(1'b0, PORT_RST_OFS, 32'h0);
      end
      chk(q, 32'h0);
      chk(preset, 4'h0);
      // Reset in mid-run: outputs to reset values, window to defaults
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({retry, preset, glb}, {4'hf, 4'h0, 1'b0});
      chk(fetch, 36'h0);
      chk(wbytes, 68'h0);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk(fetch, {9'h001, 9'h010, 9'h001, 9'h010});
      wb(1'b0, WINDOW_OFS, 32'h0);
      chk(q, 32'h0001_0f01);
      end_sim();
   end
endmodule

// >>> pkg/sccr_pkg.sv
package sccr_pkg;

   // ****************************************************
   // Register byte offsets
   // ****************************************************
   localparam logic [11:0] FEATURE_OFS = 12'h504;
   localparam logic [11:0] WINDOW_OFS = 12'h508;
   localparam logic [11:0] GLB_RST_OFS = 12'h50c;
   localparam logic [11:0] PORT_RST_OFS = 12'h510;
   localparam logic [11:0] CAP_LOW_OFS = 12'h514;
   localparam logic [11:0] CAP_MID_OFS = 12'h518;

   // ****************************************************
   // Window register field positions and the global reset bit
   // ****************************************************
   localparam int PF_LEN_LSB = 16;
   localparam int FORCE_LSB = 12;
   localparam int RETRY_LSB = 8;
   localparam int RANGE_LSB = 0;
   localparam int GLB_RST_BIT = 0;

   // ****************************************************
   // Feature word field positions
   // ****************************************************
   localparam int F_DDR = 31;
   localparam int F_PORT_ASYNC = 27;
   localparam int F_REG_ASYNC = 26;
   localparam int F_MEM_CLK = 24;
   localparam int F_UNFOLD = 21;
   localparam int F_ENGINES = 18;
   localparam int F_FFM = 16;
   localparam int F_BUS_W = 14;
   localparam int F_FLOW_SRAM = 12;
   localparam int F_EXT_BUS = 11;
   localparam int F_CMDQ = 8;
   localparam int F_PORTS = 4;
   localparam int F_CHANNELS = 0;

   // ****************************************************
   // Reset values and limits
   // ****************************************************
   localparam logic [8:0] PF_LEN_RST = 9'h001;
   localparam logic [8:0] PF_LEN_MAX = 9'h080;
   localparam logic [3:0] FORCE_RST = 4'h0;
   localparam logic [3:0] RETRY_RST = 4'hf;
   localparam logic [7:0] RANGE_RST = 8'h01;
   localparam logic [16:0] WINDOW_MIN_BYTES = 17'h00200;

   // ****************************************************
   // Burst codes and timing
   // ****************************************************
   localparam logic [2:0] BURST_INCR = 3'h1;
   localparam logic [2:0] BURST_WRAP4 = 3'h2;
   localparam logic [2:0] BURST_INCR4 = 3'h3;
   localparam logic [2:0] BURST_WRAP8 = 3'h4;
   localparam logic [2:0] BURST_INCR8 = 3'h5;
   localparam logic [2:0] BURST_WRAP16 = 3'h6;
   localparam logic [2:0] BURST_INCR16 = 3'h7;
   localparam int CLK_PERIOD_NS = 50;
   localparam int GLB_PULSE_NS = 200;
   localparam int GLB_PULSE_CYC = (GLB_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Window register contents
   typedef struct packed {
      logic [8:0] pf_len;
      logic [3:0] force_len;
      logic [3:0] retry_en;
      logic [7:0] range;
   } sccr_window_t;

   // Global reset sequencer, Gray from idle through hold; the return from hold to idle flips both bits
   typedef enum logic [1:0] {
      GR_IDLE = 2'b00,
      GR_PULSE = 2'b01,
      GR_HOLD = 2'b11
   } sccr_glb_state_t;

endpackage
